//--- bench/clk_ctl_sva.sv
// port assertions for the clock control block
`timescale 1ns/1ps
`default_nettype none
module clk_ctl_sva (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic pll_locked_i,
  input wire logic spi_mode_i,
  input wire logic dsp_clk_en_i,
  input wire logic sda_i,
  input wire logic sda_filt_o,
  input wire logic pll_power_on_o,
  input wire logic pll_clk_out_en_o,
  input wire logic crystal_osc_run_o,
  input wire logic main_clk_en_o,
  input wire logic [15:8] pll_denominator_o,
  input wire logic param_wr_o,
  input wire logic [7:0] param_addr_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // register and parameter write cycles
  sequence s_ctl_wr; wr_i && addr_i == 8'h00; endsequence
  sequence s_par_wr; wr_i && addr_i >= 8'h10; endsequence
  property p_pll_off; !pll_power_on_o |-> !pll_clk_out_en_o; endproperty
  property p_pll_out; pll_clk_out_en_o == (pll_power_on_o && main_clk_en_o); endproperty
  property p_ctl_wr; s_ctl_wr |=> main_clk_en_o == $past(wdata_i[0]) && pll_power_on_o == $past(wdata_i[7]); endproperty
  property p_xtal; s_ctl_wr |=> crystal_osc_run_o == !$past(wdata_i[4]); endproperty
  property p_den; wr_i && addr_i == 8'h01 |=> pll_denominator_o == $past(wdata_i); endproperty
  property p_lock; rd_i && addr_i == 8'h06 |=> rdata_o == {7'h00, $past(pll_locked_i)}; endproperty
  property p_par_drop; s_par_wr ##0 !(main_clk_en_o && dsp_clk_en_i) |=> !param_wr_o; endproperty
  property p_par_pass; s_par_wr ##0 main_clk_en_o && dsp_clk_en_i |=> param_wr_o && param_addr_o == $past(addr_i); endproperty
  property p_spi_byp; spi_mode_i |-> sda_filt_o == sda_i; endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll output on while powered down");
  a_pll_out: assert property (p_pll_out) else $error("pll output enable wrong");
  a_ctl_wr: assert property (p_ctl_wr) else $error("clock control write lost");
  a_xtal: assert property (p_xtal) else $error("crystal run level wrong");
  a_den: assert property (p_den) else $error("denominator high byte wrong");
  a_lock: assert property (p_lock) else $error("lock flag read wrong");
  a_par_drop: assert property (p_par_drop) else $error("parameter write not blocked");
  a_par_pass: assert property (p_par_pass) else $error("parameter write not passed");
  a_spi_byp: assert property (p_spi_byp) else $error("filter not bypassed in spi mode");
endmodule
bind codec_clock_enable_control clk_ctl_sva u_sva (.*);
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, pll_locked_i = 0, spi_mode_i = 0;
  logic dsp_clk_en_i = 0, ext_clk_en_i = 0, pll_clk_en_i = 0, sda_i = 1, scl_i = 1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, param_addr_o, param_wdata_o;
  logic sda_filt_o, scl_filt_o, pll_power_on_o, pll_clk_out_en_o, crystal_osc_run_o;
  logic main_clk_en_o, core_clk_en_o, master_clk_en_o, param_wr_o;
  logic [15:8] pll_denominator_o;
  int bad_count = 0, n_compared = 0, cyc = 0;
  codec_clock_enable_control DUT (.*);
  always #5 mclk_i = ~mclk_i;
  task chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge mclk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge mclk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o, e);
  endtask
  // forwarded parameter write, seen or not
  task pw(input logic [7:0] a, d, input logic e);
    wr(a, d);
    chk(param_wr_o, e);
    if (e) chk(param_wdata_o, d);
  endtask
  // count derived clock enables over 40 cycles
  task cnt(input logic [7:0] c, input logic e, p, input logic [7:0] ec, em);
    logic [7:0] a, b;
    @(posedge mclk_i);
    ext_clk_en_i <= e; pll_clk_en_i <= p;
    wr(8'h00, c);
    repeat (10) @(posedge mclk_i);
    a = 0; b = 0;
    repeat (40) begin
      @(negedge mclk_i);
      a += core_clk_en_o; b += master_clk_en_o;
    end
    chk(a, ec); chk(b, em);
  endtask
  // low pulse of n cycles on both control inputs
  task spk(input int n, input logic e);
    logic lo;
    lo = 0;
    for (int i = 0; i < n + 10; i++) begin
      @(posedge mclk_i);
      sda_i <= (i >= n); scl_i <= (i >= n);
      @(negedge mclk_i);
      lo |= !sda_filt_o && !scl_filt_o;
    end
    chk(lo, e);
  endtask
  task stop_test;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    chk(crystal_osc_run_o, 1'b1);
    pw(8'h10, 8'h3C, 1'b0);
    pw(8'h08, 8'h11, 1'b0);
    pw(8'h03, 8'h44, 1'b0);
    wr(8'h01, 8'hA5);
    rd(8'h01, 8'hA5);
    chk(pll_denominator_o, 8'hA5);
    @(posedge mclk_i) pll_locked_i <= 1'b1;
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hBF);
    chk({pll_clk_out_en_o, crystal_osc_run_o}, 8'h02);
    wr(8'h00, 8'h80);
    chk({pll_power_on_o, pll_clk_out_en_o}, 8'h02);
    wr(8'h00, 8'h00);
    chk(pll_power_on_o, 1'b0);
    $display("register test done");
    @(posedge mclk_i) pll_locked_i <= 1'b1;
    rd(8'h06, 8'h01);
    @(posedge mclk_i) pll_locked_i <= 1'b0;
    rd(8'h06, 8'h00);
    wr(8'h00, 8'h01);
    pw(8'h10, 8'h3C, 1'b0);
    pw(8'h08, 8'h22, 1'b1);
    @(posedge mclk_i) dsp_clk_en_i <= 1'b1;
    pw(8'h12, 8'h5A, 1'b1);
    $display("lock and parameter test done");
    cnt(8'h01, 1'b1, 1'b0, 8'd20, 8'd20);
    cnt(8'h05, 1'b1, 1'b0, 8'd40, 8'd20);
    cnt(8'h03, 1'b1, 1'b0, 8'd20, 8'd40);
    cnt(8'h01, 1'b0, 1'b1, 8'd0, 8'd0);
    @(posedge mclk_i) pll_locked_i <= 1'b1;
    cnt(8'h0F, 1'b1, 1'b1, 8'd0, 8'd0);
    cnt(8'h8F, 1'b0, 1'b1, 8'd40, 8'd40);
    cnt(8'h00, 1'b1, 1'b1, 8'd0, 8'd0);
    $display("divider test done");
    spk(2, 1'b0);
    spk(8, 1'b1);
    wr(8'h00, 8'h20);
    spk(1, 1'b1);
    wr(8'h00, 8'h00);
    @(posedge mclk_i) spi_mode_i <= 1'b1;
    spk(1, 1'b1);
    $display("filter test done");
    stop_test;
  end
endmodule
`default_nettype wire

//--- src/clk_ctl_cfg.svh
// offsets, bit positions, reset values and timing counts of the clock control block
`ifndef CLK_CTL_CFG_SVH
`define CLK_CTL_CFG_SVH
`define ADDR_CLOCK_ENABLE_CONTROL 8'h00
`define ADDR_PLL_DENOMINATOR_HIGH 8'h01
`define ADDR_PLL_SETUP_LAST 8'h06
`define ADDR_PLL_LOCK_STATUS 8'h06
`define ADDR_PARAM_FIRST 8'h10
`define BIT_PLL_ENABLE 7
`define BIT_GLITCH_FILTER_OFF 5
`define BIT_CRYSTAL_OSC_OFF 4
`define BIT_MAIN_CLOCK_SOURCE_SELECT 3
`define BIT_CORE_CLOCK_DIVIDER 2
`define BIT_MASTER_CLOCK_DIVIDER 1
`define BIT_MAIN_CLOCK_ENABLE 0
`define BIT_PLL_LOCK 0
`define RST_CLOCK_ENABLE_CONTROL 8'h00
`define RST_PLL_DENOMINATOR_HIGH 8'h00
`define CLK_CTL_MASK 8'hBF
`define SPIKE_NS 50
`define MCLK_PERIOD_NS 10
`define SPIKE_CYCLES ((`SPIKE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

//--- src/clk_ctl_pkg.sv
// types shared by the clock control block
package clk_ctl_pkg;
  typedef enum logic [2:0] {
    SW_RUN = 3'b001,
    SW_DRAIN = 3'b010,
    SW_SWAP = 3'b100
  } sw_state_t;
endpackage

//--- src/clock_divider.sv
// divide-by-1/2 stage with glitch-free ratio change
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_cfg.svh"
module clock_divider
  import clk_ctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic div_one_i,
  output logic clk_en_o
);
  typedef struct packed {
    logic phase;
    logic div_one;
    logic en;
  } div_t;
  div_t s_q, s_d;
  // ratio taken only at the end of a full output period; phase holds between source ticks
  always_comb begin
    s_d = s_q;
    s_d.phase = run_i ? ~s_q.phase : s_q.phase;
    if (run_i && (s_q.phase || s_q.div_one)) begin
      s_d.div_one = div_one_i;
      s_d.phase = 1'b0;
    end
    s_d.en = run_i && (s_d.div_one || s_d.phase);
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s_q <= '{phase: 1'b0, div_one: 1'b0, en: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign clk_en_o = s_q.en;
endmodule
`default_nettype wire

//--- src/codec_clock_enable_control.sv
// clock enable, source select and divider control of the codec
// Operation
// - PLL enable clear keeps PLL powered down and its output off.
// - PLL output runs only with PLL enable and main clock enable both set.
// - 50 ns spike filter on SDA and SCL unless bit 5 bypasses it.
// - SPI mode bypasses the spike filter regardless of bit 5.
// - bit 3 selects external pin (0) or PLL (1) as main clock.
// - bit 2 core, bit 1 master divider: 0 divides by 2, 1 by 1.
// - main clock enable clear: only clock control and PLL setup writable.
// - after main clock enable, parameter writes ignored until DSP clock enable.
// - bit 4 set stops the crystal oscillator, clear keeps it running.
// - lock flag reads in bit 0 at offset 0x06.
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_cfg.svh"
module codec_clock_enable_control
  import clk_ctl_pkg::*;
#(
  parameter int unsigned SPIKE_CYCLES = `SPIKE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic pll_locked_i,
  input wire logic spi_mode_i,
  input wire logic dsp_clk_en_i,
  input wire logic ext_clk_en_i,
  input wire logic pll_clk_en_i,
  input wire logic sda_i,
  input wire logic scl_i,
  output logic sda_filt_o,
  output logic scl_filt_o,
  output logic pll_power_on_o,
  output logic pll_clk_out_en_o,
  output logic crystal_osc_run_o,
  output logic main_clk_en_o,
  output logic core_clk_en_o,
  output logic master_clk_en_o,
  output logic [15:8] pll_denominator_o,
  output logic param_wr_o,
  output logic [7:0] param_addr_o,
  output logic [7:0] param_wdata_o
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] den_hi;
    logic [7:0] rdata;
    sw_state_t sw;
    logic src_pll;
    logic param_wr;
    logic [7:0] param_addr;
    logic [7:0] param_wdata;
  } state_t;
  state_t s_q, s_d;

  // control register fields
  logic pll_en;
  logic main_en;
  logic src_req;
  logic filt_off;
  logic xtal_off;
  logic core_div_one;
  logic mst_div_one;

  // address decode results
  logic hit_ctl;
  logic hit_den;
  logic hit_setup;
  logic hit_lock;
  logic hit_plain;
  logic hit_param;

  // write and read qualifiers
  logic wr_ok;
  logic wr_ctl;
  logic wr_den;
  logic wr_fwd;
  logic [7:0] rd_word;

  // clock path helpers
  logic filt_bypass;
  logic src_clk_en;
  logic div_run;
  logic core_en;
  logic mst_en;
  logic swap_pending;
  logic drained;

  // control register fields, one name each
  assign pll_en = s_q.ctl[`BIT_PLL_ENABLE];
  assign main_en = s_q.ctl[`BIT_MAIN_CLOCK_ENABLE];
  assign src_req = s_q.ctl[`BIT_MAIN_CLOCK_SOURCE_SELECT];
  assign filt_off = s_q.ctl[`BIT_GLITCH_FILTER_OFF];
  assign xtal_off = s_q.ctl[`BIT_CRYSTAL_OSC_OFF];
  assign core_div_one = s_q.ctl[`BIT_CORE_CLOCK_DIVIDER];
  assign mst_div_one = s_q.ctl[`BIT_MASTER_CLOCK_DIVIDER];

  // filter bypass by bit or by spi mode
  assign filt_bypass = filt_off | spi_mode_i;

  // source gate of the currently selected clock
  always_comb begin
    src_clk_en = 1'b0;
    if (s_q.src_pll) begin
      src_clk_en = pll_clk_en_i & pll_clk_out_en_o;
    end else begin
      src_clk_en = ext_clk_en_i;
    end
  end

  // switch bookkeeping: pending request, both outputs idle
  assign swap_pending = (src_req != s_q.src_pll);
  assign drained = !core_en && !mst_en;

  // dividers stop while draining for a source change
  assign div_run = main_en && (s_q.sw == SW_RUN) && src_clk_en;

  // address decode, one region per address range
  always_comb begin
    hit_ctl = 1'b0;
    hit_den = 1'b0;
    hit_setup = 1'b0;
    hit_lock = 1'b0;
    hit_plain = 1'b0;
    hit_param = 1'b0;
    if (addr_i == `ADDR_CLOCK_ENABLE_CONTROL) begin
      hit_ctl = 1'b1;
    end else if (addr_i == `ADDR_PLL_DENOMINATOR_HIGH) begin
      hit_den = 1'b1;
    end else if (addr_i == `ADDR_PLL_LOCK_STATUS) begin
      hit_lock = 1'b1;
    end else if (addr_i < `ADDR_PLL_SETUP_LAST) begin
      hit_setup = 1'b1;
    end else if (addr_i < `ADDR_PARAM_FIRST) begin
      hit_plain = 1'b1;
    end else begin
      hit_param = 1'b1;
    end
  end

  // accepted writes, split by target
  assign wr_ctl = wr_i && hit_ctl;
  assign wr_den = wr_i && hit_den;
  assign wr_fwd = wr_i && wr_ok && (hit_plain || hit_param);

  // read mux; setup and unmapped addresses read zero
  always_comb begin
    rd_word = 8'h00;
    if (hit_ctl) begin
      rd_word = s_q.ctl;
    end else if (hit_den) begin
      rd_word = s_q.den_hi;
    end else if (hit_lock) begin
      rd_word = {7'h00, pll_locked_i};
    end else begin
      rd_word = 8'h00;
    end
  end

  // write gating: clocks off allows only clock and PLL setup registers
  always_comb begin
    wr_ok = 1'b0;
    if (hit_ctl || hit_den || hit_setup || hit_lock) begin
      wr_ok = 1'b1;
    end else if (!main_en) begin
      wr_ok = 1'b0;
    end else if (hit_param) begin
      wr_ok = dsp_clk_en_i;
    end else begin
      wr_ok = 1'b1;
    end
  end

  // register writes, reads, and source switch sequencing
  always_comb begin
    s_d = s_q;
    // forwarded write pulse lasts one cycle
    s_d.param_wr = wr_fwd;
    // control register keeps its reserved bit at zero
    if (wr_ctl) begin
      s_d.ctl = wdata_i & `CLK_CTL_MASK;
    end
    // denominator high byte
    if (wr_den) begin
      s_d.den_hi = wdata_i;
    end
    // parameter and ordinary register writes leave the block
    if (wr_fwd) begin
      s_d.param_addr = addr_i;
      s_d.param_wdata = wdata_i;
    end
    // read data stand for the one cycle after the strobe
    s_d.rdata = 8'h00;
    if (rd_i) begin
      s_d.rdata = rd_word;
    end
    // stop outputs, swap source, resume
    case (s_q.sw)
      // dividers run; a new source request starts the drain
      SW_RUN: begin
        if (swap_pending) begin
          s_d.sw = SW_DRAIN;
        end else begin
          s_d.sw = SW_RUN;
        end
      end
      // wait until neither derived enable is high
      SW_DRAIN: begin
        if (drained) begin
          s_d.sw = SW_SWAP;
        end else begin
          s_d.sw = SW_DRAIN;
        end
      end
      // take the new source, then resume
      SW_SWAP: begin
        s_d.src_pll = src_req;
        s_d.sw = SW_RUN;
      end
      default: begin
        s_d.sw = SW_RUN;
      end
    endcase
  end

  // state register with reset values
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s_q.ctl <= `RST_CLOCK_ENABLE_CONTROL;
      s_q.den_hi <= `RST_PLL_DENOMINATOR_HIGH;
      s_q.rdata <= 8'h00;
      s_q.sw <= SW_RUN;
      s_q.src_pll <= 1'b0;
      s_q.param_wr <= 1'b0;
      s_q.param_addr <= 8'h00;
      s_q.param_wdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // core and master divide stages
  clock_divider u_core_div (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_i(div_run),
    .div_one_i(core_div_one),
    .clk_en_o(core_en)
  );
  clock_divider u_master_div (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_i(div_run),
    .div_one_i(mst_div_one),
    .clk_en_o(mst_en)
  );

  // control-port spike filters
  spike_filter #(.CYCLES(SPIKE_CYCLES)) u_sda_filt (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .bypass_i(filt_bypass),
    .raw_i(sda_i),
    .out_o(sda_filt_o)
  );
  spike_filter #(.CYCLES(SPIKE_CYCLES)) u_scl_filt (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .bypass_i(filt_bypass),
    .raw_i(scl_i),
    .out_o(scl_filt_o)
  );

  // PLL power and output gate
  assign pll_power_on_o = pll_en;
  assign pll_clk_out_en_o = pll_en & main_en;

  // oscillator and main clock
  assign crystal_osc_run_o = ~xtal_off;
  assign main_clk_en_o = main_en;

  // derived clock enables
  assign core_clk_en_o = core_en;
  assign master_clk_en_o = mst_en;

  // denominator high byte
  assign pll_denominator_o = s_q.den_hi;

  // registered read data
  assign rdata_o = s_q.rdata;

  // forwarded write
  assign param_wr_o = s_q.param_wr;
  assign param_addr_o = s_q.param_addr;
  assign param_wdata_o = s_q.param_wdata;
endmodule
`default_nettype wire

//--- src/spike_filter.sv
// spike suppression filter for one control-port input
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctl_cfg.svh"
module spike_filter
  import clk_ctl_pkg::*;
#(
  parameter int unsigned CYCLES = `SPIKE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic bypass_i,
  input wire logic raw_i,
  output logic out_o
);
  typedef struct packed {
    logic stable;
    logic [7:0] cnt;
  } filt_t;
  filt_t s_q, s_d;
  // a new level must persist CYCLES clocks before it passes
  always_comb begin
    s_d = s_q;
    if (raw_i == s_q.stable) begin
      s_d.cnt = 8'h00;
    end else if (s_q.cnt >= 8'(CYCLES - 1)) begin
      s_d.stable = raw_i;
      s_d.cnt = 8'h00;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s_q <= '{stable: 1'b1, cnt: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end
  assign out_o = bypass_i ? raw_i : s_q.stable;
endmodule
`default_nettype wire
